/* File: erc_counters.sv */
// receive error counter bank with an Avalon-MM slave and a level interrupt
`timescale 1ns/1ps
module erc_counters
(
	input  wire logic                      clock,
	input  wire logic                      reset,
	input  wire erc_pkg::erc_evt_t         events,
	input  wire erc_pkg::erc_req_t         avs_req,
	output logic [erc_pkg::DATA_W-1:0]     avs_readdata,
	output logic                           avs_waitrequest,
	output logic                           irq
);

	//------------------------------------------------------------
	// bus decode
	//------------------------------------------------------------
	logic [erc_pkg::CNT_W-1:0] count [erc_pkg::NUM_CNT];
	logic [erc_pkg::CNT_W-1:0] snap  [erc_pkg::NUM_CNT];
	logic [erc_pkg::NUM_CNT-1:0] armed;
	logic [erc_pkg::NUM_CNT-1:0] int_stat;
	logic [erc_pkg::NUM_CNT-1:0] int_mask;
	logic [erc_pkg::NUM_CNT-1:0] sat_set;

	wire        req      = avs_req.read | avs_req.write;
	// reads act at the edge that starts the access, the master holds it anyway
	wire        start_rd = avs_req.read & avs_waitrequest;
	// writes act only at the edge where waitrequest is seen low
	wire        accept_wr = avs_req.write & ~avs_waitrequest;
	wire [13:0] idx      = avs_req.address[15:2];

	wire sel_lcv_hi = (idx == erc_pkg::IDX_LCV_HIGH);
	wire sel_lcv_lo = (idx == erc_pkg::IDX_LCV_LOW);
	wire sel_fae_hi = (idx == erc_pkg::IDX_FAE_HIGH);
	wire sel_fae_lo = (idx == erc_pkg::IDX_FAE_LOW);
	wire sel_stat   = (idx == erc_pkg::IDX_INT_STAT);
	wire sel_mask   = (idx == erc_pkg::IDX_INT_MASK);

	wire [erc_pkg::NUM_CNT-1:0] sel_hi = {sel_fae_hi, sel_lcv_hi};
	wire [erc_pkg::NUM_CNT-1:0] sel_lo = {sel_fae_lo, sel_lcv_lo};
	wire [erc_pkg::NUM_CNT-1:0] evt    = {events.fae, events.lcv};

	wire wr_low_lane = accept_wr & avs_req.byteenable[0];
	wire stat_clr_en = wr_low_lane & sel_stat;
	wire mask_wr_en  = wr_low_lane & sel_mask;

	//------------------------------------------------------------
	// read data selection
	//------------------------------------------------------------
	wire [7:0] lcv_lo_byte = armed[erc_pkg::SLOT_LCV] ?
		snap[erc_pkg::SLOT_LCV][7:0] : count[erc_pkg::SLOT_LCV][7:0];
	wire [7:0] fae_lo_byte = armed[erc_pkg::SLOT_FAE] ?
		snap[erc_pkg::SLOT_FAE][7:0] : count[erc_pkg::SLOT_FAE][7:0];

	logic [31:0] next_readdata;
	always_comb
	begin
		if (sel_lcv_hi)
			next_readdata = {24'h00_0000, count[erc_pkg::SLOT_LCV][15:8]};
		else if (sel_lcv_lo)
			next_readdata = {24'h00_0000, lcv_lo_byte};
		else if (sel_fae_hi)
			next_readdata = {24'h00_0000, count[erc_pkg::SLOT_FAE][15:8]};
		else if (sel_fae_lo)
			next_readdata = {24'h00_0000, fae_lo_byte};
		else if (sel_stat)
			next_readdata = {30'h0000_0000, int_stat};
		else if (sel_mask)
			next_readdata = {30'h0000_0000, int_mask};
		else
			next_readdata = erc_pkg::RD_ZERO;
	end

	//------------------------------------------------------------
	// slave handshake: one wait cycle, then the answer
	//------------------------------------------------------------
	wire next_waitrequest = ~(req & avs_waitrequest);

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= erc_pkg::RD_ZERO;
		end
		else
		begin
			avs_waitrequest <= next_waitrequest;
			if (start_rd)
				avs_readdata <= next_readdata;
		end
	end

	//------------------------------------------------------------
	// counters
	//------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < erc_pkg::NUM_CNT; i++)
		begin : g_cnt
			// saturate rather than wrap so a full count never reads as small
			wire       inc      = evt[i] & (count[i] != erc_pkg::CNT_MAX);
			wire       rd_hi    = start_rd & sel_hi[i];
			// only a low read that follows a high read clears
			wire       rd_clear = start_rd & sel_lo[i] & armed[i];
			// events since the high read survive the clear
			wire [15:0] next_count = rd_clear ?
				16'(count[i] - snap[i] + {15'h0000, inc}) :
				16'(count[i] + {15'h0000, inc});

			assign sat_set[i] = (next_count == erc_pkg::CNT_MAX) &&
				(count[i] != erc_pkg::CNT_MAX);

			always_ff @(posedge clock)
			begin
				if (reset)
				begin
					count[i] <= erc_pkg::CNT_RESET;
					snap[i]  <= erc_pkg::CNT_RESET;
					armed[i] <= 1'b0;
				end
				else
				begin
					count[i] <= next_count;
					if (rd_hi)
					begin
						snap[i]  <= count[i];
						armed[i] <= 1'b1;
					end
					else if (rd_clear)
						armed[i] <= 1'b0;
				end
			end
		end
	endgenerate

	//------------------------------------------------------------
	// interrupt: sticky saturation flags, write one to clear
	//------------------------------------------------------------
	wire [1:0] stat_clr  = stat_clr_en ? avs_req.writedata[1:0] : 2'h0;
	// a set in the clearing cycle wins
	wire [1:0] next_stat = (int_stat & ~stat_clr) | sat_set;

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			int_stat <= erc_pkg::INT_RESET;
			int_mask <= erc_pkg::INT_RESET;
			irq      <= 1'b0;
		end
		else
		begin
			int_stat <= next_stat;
			if (mask_wr_en)
				int_mask <= avs_req.writedata[1:0];
			irq <= |(next_stat & (mask_wr_en ? avs_req.writedata[1:0] : int_mask));
		end
	end

endmodule

/* File: erc_pkg.sv */
// package: register map, field layout and types of the receive error counter bank
//------------------------------------------------------------
// Function
//------------------------------------------------------------
// Function
// - keep a 16-bit line code violation count since last read
// - low byte register shows count bits 7..0, cleared by reading; here a low read clears only when it follows a high byte read
// - framing error high byte register returns count bits 15..8
// - framing error low byte register returns count bits 7..0
// - counts reset to zero and restart from zero after being read; here the clearing low read keeps the events counted since the high read
// - line code violation high byte register returns count bits 15..8
package erc_pkg;

	//------------------------------------------------------------
	// register indices; byte address is four times the index
	//------------------------------------------------------------
	localparam logic [13:0] IDX_LCV_HIGH  = 14'h0900;
	localparam logic [13:0] IDX_LCV_LOW   = 14'h0901;
	localparam logic [13:0] IDX_FAE_HIGH  = 14'h0902;
	localparam logic [13:0] IDX_FAE_LOW   = 14'h0903;
	localparam logic [13:0] IDX_INT_STAT  = 14'h0904;
	localparam logic [13:0] IDX_INT_MASK  = 14'h0905;

	localparam int          ADDR_W        = 16;
	localparam int          DATA_W        = 32;
	localparam int          CNT_W         = 16;
	localparam int          NUM_CNT       = 2;

	//------------------------------------------------------------
	// counter slots, status and mask bit positions
	//------------------------------------------------------------
	localparam int          SLOT_LCV      = 0;
	localparam int          SLOT_FAE      = 1;

	localparam logic [15:0] CNT_RESET     = 16'h0000;
	localparam logic [15:0] CNT_MAX       = 16'hFFFF;
	localparam logic [1:0]  INT_RESET     = 2'h0;
	localparam logic [31:0] RD_ZERO       = 32'h0000_0000;

	//------------------------------------------------------------
	// types
	//------------------------------------------------------------
	typedef struct packed {
		logic fae;
		logic lcv;
	} erc_evt_t;

	typedef struct packed {
		logic              read;
		logic              write;
		logic [ADDR_W-1:0] address;
		logic [3:0]        byteenable;
		logic [DATA_W-1:0] writedata;
	} erc_req_t;

endpackage

/* File: erc_counters_assertions.sv */
// checker: bus timing, read data shape and interrupt cause
`timescale 1ns/1ps
module erc_counters_assertions
(
	input wire logic                        clock,
	input wire logic                        reset,
	input wire erc_pkg::erc_evt_t           events,
	input wire erc_pkg::erc_req_t           avs_req,
	input wire logic [erc_pkg::DATA_W-1:0]  avs_readdata,
	input wire logic                        avs_waitrequest,
	input wire logic                        irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	wire        req = avs_req.read || avs_req.write;
	wire [13:0] idx = avs_req.address[15:2];
	sequence rd_start; avs_req.read && avs_waitrequest; endsequence
	sequence one_wait; !avs_waitrequest ##1 avs_waitrequest; endsequence
	wait_one_a: assert property (req && avs_waitrequest |=> one_wait) else $error("wait not one");
	idle_wait_a: assert property (!req |=> avs_waitrequest) else $error("idle answer");
	fell_cause_a: assert property ($fell(avs_waitrequest) |-> $past(req)) else $error("no request");
	upper_zero_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
		else $error("upper bits set");
	unmapped_a: assert property (rd_start ##0 (idx < 14'h0900 || idx > 14'h0905)
		|=> avs_readdata == 32'h0) else $error("unmapped not zero");
	hold_data_a: assert property (!(avs_req.read && avs_waitrequest) |=> $stable(avs_readdata))
		else $error("read data moved");
	stat_bits_a: assert property (rd_start ##0 (idx > 14'h0903 && idx < 14'h0906)
		|=> avs_readdata[31:2] == 30'h0) else $error("status width");
	irq_fall_a: assert property ($fell(irq) |-> $past(avs_req.write) || $past(avs_req.write, 2))
		else $error("irq fell alone");
endmodule
bind erc_counters erc_counters_assertions erc_counters_assertions_inst (.clock(clock),
	.reset(reset), .events(events), .avs_req(avs_req), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .irq(irq));

/* File: erc_counters_tb.sv */
// self-checking bench for the receive error counter bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD %s exp %0h got %0h", n, e, g); end end
module erc_counters_tb;
	logic                        clock;
	logic                        reset;
	erc_pkg::erc_evt_t           events;
	erc_pkg::erc_req_t           avs_req;
	logic [erc_pkg::DATA_W-1:0]  avs_readdata;
	logic                        avs_waitrequest;
	logic                        irq;
	logic [31:0]                 d;
	int                          n_fail;
	int                          num_checks;
	erc_counters erc_counters_inst (.clock(clock), .reset(reset), .events(events),
		.avs_req(avs_req), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.irq(irq));
	initial
	begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end
	// request held until the rising edge that sees waitrequest low, data taken there
	task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] wd);
		@(posedge clock);
		avs_req <= '{read: !w, write: w, address: a, byteenable: 4'hF, writedata: wd};
		do @(posedge clock); while (avs_waitrequest !== 1'h0);
		d = avs_readdata;
		avs_req <= '0;
	endtask
	task automatic chk(input string n, input logic [15:0] a, input logic [7:0] e);
		acc(1'h0, a, 32'h0);
		`CHK(n, {24'h0, e}, d)
	endtask
	task automatic ev(input logic [1:0] e, input int n);
		@(posedge clock);
		events <= e;
		repeat (n) @(posedge clock);
		events <= 2'h0;
	endtask
	task automatic t_reset;
		chk("lcv_hi", 16'h2400, 8'h00);
		chk("lcv_lo", 16'h2404, 8'h00);
		chk("fae_hi", 16'h2408, 8'h00);
		chk("fae_lo", 16'h240C, 8'h00);
		chk("unmapped", 16'h2418, 8'h00);
		$display("t_reset done");
	endtask
	task automatic t_lcv;
		ev(2'h1, 300);
		chk("lcv_hi", 16'h2400, 8'h01);
		chk("lcv_lo", 16'h2404, 8'h2C);
		chk("lcv_hi0", 16'h2400, 8'h00);
		chk("lcv_lo0", 16'h2404, 8'h00);
		$display("t_lcv done");
	endtask
	// low read first must not clear; events after the snapshot survive
	task automatic t_fae;
		ev(2'h2, 261);
		chk("fae_live", 16'h240C, 8'h05);
		chk("fae_hi", 16'h2408, 8'h01);
		ev(2'h3, 3);
		chk("fae_snap", 16'h240C, 8'h05);
		chk("fae_hi2", 16'h2408, 8'h00);
		chk("fae_lo2", 16'h240C, 8'h03);
		chk("lcv_hi", 16'h2400, 8'h00);
		chk("lcv_lo", 16'h2404, 8'h03);
		$display("t_fae done");
	endtask
	task automatic t_irq;
		ev(2'h1, 65540);
		chk("sat_hi", 16'h2400, 8'hFF);
		chk("sat_lo", 16'h2404, 8'hFF);
		chk("status", 16'h2410, 8'h01);
		`CHK("irq_masked", 1'h0, irq)
		acc(1'h1, 16'h2414, 32'h1);
		repeat (2) @(posedge clock);
		`CHK("irq_on", 1'h1, irq)
		acc(1'h1, 16'h2410, 32'h1);
		repeat (2) @(posedge clock);
		`CHK("irq_off", 1'h0, irq)
		chk("status0", 16'h2410, 8'h00);
		$display("t_irq done");
	endtask
	task automatic final_report;
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (70000) @(posedge clock);
		n_fail++;
		final_report();
	end
	initial
	begin
		reset = 1'h1;
		events = 2'h0;
		avs_req = '0;
		n_fail = 0;
		num_checks = 0;
		repeat (5) @(posedge clock);
		reset <= 1'h0;
		t_reset();
		t_lcv();
		t_fae();
		t_irq();
		final_report();
	end
endmodule
